// File: rtl/ext_clock_router.sv
// External clock line routing for three channels.
// Assumes pin inputs are already synchronised by the caller.
module ext_clock_router (
  // Selector codes
  input wire logic [5:0] lineSel,
  // Sources
  input wire timer_block_pkg::clock_sources_type sources,
  // Routed lines
  output logic [2:0] extLine
);

  // One selector, picking pin, nothing or one of two waveforms
  function automatic logic pickLine(input logic [1:0] code, input logic pin,
                                    input logic waveLo, input logic waveHi);
    case (code)
      timer_block_pkg::SEL_PIN: pickLine = pin;
      timer_block_pkg::SEL_WAVE_LO: pickLine = waveLo;
      timer_block_pkg::SEL_WAVE_HI: pickLine = waveHi;
      default: pickLine = 1'b0;
    endcase
  endfunction : pickLine

  wire logic [1:0] sel0 = lineSel[timer_block_pkg::LINE0_SEL_LSB +: 2];
  wire logic [1:0] sel1 = lineSel[timer_block_pkg::LINE1_SEL_LSB +: 2];
  wire logic [1:0] sel2 = lineSel[timer_block_pkg::LINE2_SEL_LSB +: 2];

  // Line 0: pin 0, none, channel 1 wave, channel 2 wave
  assign extLine[0] = pickLine(sel0, sources.clockPin[0], sources.waveA[1],
                               sources.waveA[2]);
  // Line 1: pin 1, none, channel 0 wave, channel 2 wave
  assign extLine[1] = pickLine(sel1, sources.clockPin[1], sources.waveA[0],
                               sources.waveA[2]);
  // Line 2: pin 2, none, channel 0 wave, channel 1 wave
  assign extLine[2] = pickLine(sel2, sources.clockPin[2], sources.waveA[0],
                               sources.waveA[1]);

endmodule : ext_clock_router

// File: rtl/timer_block_pkg.sv
// Constants and carrier types for the timer block register logic.
// Assumes a 32-bit AXI4-Lite register bus and three counter channels.
package timer_block_pkg;

  // Register byte offsets; channel n adds n times the channel stride
  localparam logic [7:0] CHAN_STRIDE = 8'h40;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h24;
  localparam logic [7:0] IRQ_DISABLE_OFS = 8'h28;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h2c;
  localparam logic [7:0] STATUS_OFS = 8'h20;
  localparam logic [7:0] BLOCK_CONTROL_OFS = 8'hc0;
  localparam logic [7:0] BLOCK_MODE_OFS = 8'hc4;
  localparam logic [7:0] CAPABILITY_OFS = 8'hf8;
  localparam logic [7:0] REVISION_OFS = 8'hfc;

  // Field positions and widths
  localparam int EVENT_BITS = 8;
  localparam int SYNC_BIT = 0;
  localparam int LINE0_SEL_LSB = 0;
  localparam int LINE1_SEL_LSB = 2;
  localparam int LINE2_SEL_LSB = 4;
  localparam int BRIDGE_BIT = 9;
  localparam int UPDOWN_BIT = 8;
  localparam int VARIANT_LSB = 16;

  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [5:0] MODE_RESET = 6'h00;

  // Capability and revision contents; revision values are arbitrary
  localparam logic [7:0] COUNTER_WIDTH = 8'h10;
  localparam logic [11:0] REVISION_NUMBER = 12'h123;
  localparam logic [3:0] VARIANT_NUMBER = 4'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // External clock line selector codes
  typedef enum logic [1:0] {
    SEL_PIN = 2'h0,
    SEL_NONE = 2'h1,
    SEL_WAVE_LO = 2'h2,
    SEL_WAVE_HI = 2'h3
  } line_sel_type;

  // Per-channel event flags, bit 7 to bit 0
  typedef struct packed {
    logic extTriggerEvent;
    logic loadBEvent;
    logic loadAEvent;
    logic compareCEvent;
    logic compareBEvent;
    logic compareAEvent;
    logic loadOverrunEvent;
    logic overflowEvent;
  } event_flags_type;

  // Pin and waveform lines seen by the clock router
  typedef struct packed {
    logic [2:0] clockPin;
    logic [2:0] waveA;
  } clock_sources_type;

endpackage : timer_block_pkg

// File: rtl/timer_block_regs.sv
// Block register logic of a three-channel timer: masks, sync, routing.
// Assumes channel cores supply event pulses and waveform A outputs.
module timer_block_regs #(
  parameter int CHANNELS = 3,
  parameter logic BRIDGE_KIND = 1'b1,
  parameter logic UPDOWN_PRESENT = 1'b0
) (
  // Clock and reset; each instance gets its own bus clock
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel event pulses and waveform outputs
  input wire timer_block_pkg::event_flags_type [2:0] eventPulse,
  input wire logic [2:0] waveA,
  // Clock pins from outside
  input wire logic [2:0] clockPin,
  // Per-channel counter clock select, from channel mode logic
  input wire logic [8:0] counterClockSelect,
  // Outputs to channels
  output logic syncTrigger,
  output logic [2:0] extLine,
  output logic [2:0] extClockPick,
  output logic [2:0] chanIrq
);

  // Elaboration check: the decode serves exactly three channels
  if (CHANNELS != 3) begin : g_bad_channels
    $error("timer_block_regs serves exactly three channels");
  end

  // Reset release through two flops
  logic rstSync1_ff;
  logic rstSync2_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end
  wire logic rstnInt = rstSync2_ff;

  // Checks run on the bus clock and rest while in reset
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstnInt);

  // Clock pins pass two flops before routing
  logic [2:0] pinMeta_ff;
  logic [2:0] pinSync_ff;
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      pinMeta_ff <= 3'h0;
      pinSync_ff <= 3'h0;
    end else begin
      pinMeta_ff <= clockPin;
      pinSync_ff <= pinMeta_ff;
    end
  end

  // Write channel capture: address and data in either order
  logic [7:0] awAddr_ff;
  logic awHeld_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic wHeld_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;

  assign s_axi_awready = !awHeld_ff && !bValid_ff;
  assign s_axi_wready = !wHeld_ff && !bValid_ff;
  wire logic awTake = s_axi_awvalid && s_axi_awready;
  wire logic wTake = s_axi_wvalid && s_axi_wready;
  wire logic writeFire = awHeld_ff && wHeld_ff && !bValid_ff;

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      awAddr_ff <= 8'h00;
      awHeld_ff <= 1'b0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      wHeld_ff <= 1'b0;
    end else begin
      if (awTake) begin
        awAddr_ff <= s_axi_awaddr;
        awHeld_ff <= 1'b1;
      end else if (writeFire) begin
        awHeld_ff <= 1'b0;
      end
      if (wTake) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
        wHeld_ff <= 1'b1;
      end else if (writeFire) begin
        wHeld_ff <= 1'b0;
      end
    end
  end

  // Register decode for a channel-relative offset
  function automatic logic chanHit(input logic [7:0] addr,
                                   input logic [7:0] ofs, input int ch);
    logic [7:0] base;
    base = ofs + 8'(ch) * timer_block_pkg::CHAN_STRIDE;
    chanHit = (addr == base);
  endfunction : chanHit

  // Write decode
  logic [2:0] wrEnable;
  logic [2:0] wrDisable;
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      wrEnable[c] = writeFire
        && chanHit(awAddr_ff, timer_block_pkg::IRQ_ENABLE_OFS, c);
      wrDisable[c] = writeFire
        && chanHit(awAddr_ff, timer_block_pkg::IRQ_DISABLE_OFS, c);
    end
  end
  wire logic wrControl = writeFire
    && (awAddr_ff == timer_block_pkg::BLOCK_CONTROL_OFS);
  wire logic wrMode = writeFire
    && (awAddr_ff == timer_block_pkg::BLOCK_MODE_OFS);
  wire logic wrKnown = (|wrEnable) || (|wrDisable) || wrControl || wrMode;
  wire logic lowLane = wStrb_ff[0];

  // Write response
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      bValid_ff <= 1'b0;
      bResp_ff <= timer_block_pkg::RESP_OKAY;
    end else if (writeFire) begin
      bValid_ff <= 1'b1;
      bResp_ff <= wrKnown ? timer_block_pkg::RESP_OKAY
                          : timer_block_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;

  // Interrupt masks, set and cleared bitwise by write-one
  logic [7:0] mask_ff [3];
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      for (int c = 0; c < 3; c++) begin
        mask_ff[c] <= timer_block_pkg::MASK_RESET;
      end
    end else begin
      for (int c = 0; c < 3; c++) begin
        if (wrEnable[c] && lowLane) begin
          mask_ff[c] <= mask_ff[c] | wData_ff[7:0];
        end else if (wrDisable[c] && lowLane) begin
          mask_ff[c] <= mask_ff[c] & ~wData_ff[7:0];
        end
      end
    end
  end

  // Block mode: external line selectors
  logic [5:0] mode_ff;
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      mode_ff <= timer_block_pkg::MODE_RESET;
    end else if (wrMode && lowLane) begin
      mode_ff <= wData_ff[5:0];
    end
  end

  // Sync pulse to every channel in the write cycle
  assign syncTrigger = wrControl && lowLane
    && wData_ff[timer_block_pkg::SYNC_BIT];

  // Read channel
  logic rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0] rResp_ff;
  assign s_axi_arready = !rValid_ff;
  wire logic arTake = s_axi_arvalid && s_axi_arready;

  logic [2:0] rdStatus;
  logic [2:0] rdMask;
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      rdStatus[c] = arTake
        && chanHit(s_axi_araddr, timer_block_pkg::STATUS_OFS, c);
      rdMask[c] = chanHit(s_axi_araddr, timer_block_pkg::IRQ_MASK_OFS, c);
    end
  end

  // Pending flags: set wins over clear-on-read
  logic [7:0] flags_ff [3];
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      for (int c = 0; c < 3; c++) begin
        flags_ff[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < 3; c++) begin
        flags_ff[c] <= (rdStatus[c] ? 8'h00 : flags_ff[c])
          | eventPulse[c];
      end
    end
  end

  // Capability and revision words
  wire logic [31:0] capWord = {22'h0, BRIDGE_KIND, UPDOWN_PRESENT,
                               timer_block_pkg::COUNTER_WIDTH};
  wire logic [31:0] revWord = {12'h0, timer_block_pkg::VARIANT_NUMBER,
                               4'h0, timer_block_pkg::REVISION_NUMBER};

  // Read mux
  logic [31:0] rdWord;
  logic rdKnown;
  always_comb begin
    rdWord = 32'h0000_0000;
    rdKnown = 1'b0;
    for (int c = 0; c < 3; c++) begin
      if (rdMask[c]) begin
        rdWord = {24'h0, mask_ff[c]};
        rdKnown = 1'b1;
      end
      if (chanHit(s_axi_araddr, timer_block_pkg::STATUS_OFS, c)) begin
        rdWord = {24'h0, flags_ff[c]};
        rdKnown = 1'b1;
      end
    end
    if (s_axi_araddr == timer_block_pkg::BLOCK_MODE_OFS) begin
      rdWord = {26'h0, mode_ff};
      rdKnown = 1'b1;
    end
    if (s_axi_araddr == timer_block_pkg::CAPABILITY_OFS) begin
      rdWord = capWord;
      rdKnown = 1'b1;
    end
    if (s_axi_araddr == timer_block_pkg::REVISION_OFS) begin
      rdWord = revWord;
      rdKnown = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      rValid_ff <= 1'b0;
      rData_ff <= 32'h0000_0000;
      rResp_ff <= timer_block_pkg::RESP_OKAY;
    end else if (arTake) begin
      rValid_ff <= 1'b1;
      rData_ff <= rdWord;
      rResp_ff <= rdKnown ? timer_block_pkg::RESP_OKAY
                          : timer_block_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

  // Interrupt request per channel
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      chanIrq[c] = |(flags_ff[c] & mask_ff[c]);
    end
  end

  // External clock routing; combinational, only the pin flops run on this instance's bus clock
  timer_block_pkg::clock_sources_type routeSrc;
  assign routeSrc = '{clockPin: pinSync_ff, waveA: waveA};
  ext_clock_router router (
    .lineSel(mode_ff),
    .sources(routeSrc),
    .extLine(extLine)
  );

  // Codes 5..7 of a channel clock select pick lines 0..2
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      case (counterClockSelect[c*3 +: 3])
        3'h5: extClockPick[c] = extLine[0];
        3'h6: extClockPick[c] = extLine[1];
        3'h7: extClockPick[c] = extLine[2];
        default: extClockPick[c] = 1'b0;
      endcase
    end
  end

  // Checks
  AST_ENABLE_SETS: assert property (
    wrEnable[0] && lowLane |=> (mask_ff[0] & $past(wData_ff[7:0]))
      == $past(wData_ff[7:0]))
    else $error("enable did not set mask");
  AST_DISABLE_CLEARS: assert property (
    wrDisable[1] && lowLane |=> (mask_ff[1] & $past(wData_ff[7:0]))
      == 8'h00)
    else $error("disable did not clear mask");
  AST_ZERO_KEEPS: assert property (
    (wrEnable[2] || wrDisable[2]) |=> ((mask_ff[2] ^ $past(mask_ff[2]))
      & ~$past(wData_ff[7:0])) == 8'h00)
    else $error("zero bit changed mask");
  AST_MASK_STABLE: assert property (
    !wrEnable[0] && !wrDisable[0] |=> $stable(mask_ff[0]))
    else $error("mask changed without write");
  AST_SYNC_PULSE: assert property (
    syncTrigger |-> writeFire ##1 !syncTrigger)
    else $error("sync not a single pulse");
  AST_LINE0_WAVE: assert property (
    mode_ff[1:0] == 2'h3 |-> extLine[0] == waveA[2])
    else $error("line 0 route wrong");
  AST_STATUS_CLEAR: assert property (
    rdStatus[0] && eventPulse[0] == 8'h00 |=> flags_ff[0] == 8'h00)
    else $error("status read did not clear");
  AST_IRQ_FOLLOWS: assert property (
    (|(eventPulse[2] & mask_ff[2])) && !wrDisable[2] |=> chanIrq[2])
    else $error("unmasked event gave no interrupt");

endmodule : timer_block_regs

// File: testbench/testbench.sv
// Self-checking bench for the timer block register logic.
// Drives the AXI4-Lite slave, event pulses, pins and waves directly.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // Bench signals
  logic clk;
  logic rstn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  timer_block_pkg::event_flags_type [2:0] eventPulse;
  logic [2:0] waveA;
  logic [2:0] clockPin;
  logic [8:0] ccSel;
  logic syncTrigger;
  logic [2:0] extLine;
  logic [2:0] extClockPick;
  logic [2:0] chanIrq;
  logic [31:0] rd;
  logic [1:0] rsp;
  int n_mismatch = 0;
  int cmp_count = 0;
  int pulses = 0;

  // Device under test
  timer_block_regs i_dut (
    .clk(clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .eventPulse(eventPulse), .waveA(waveA), .clockPin(clockPin),
    .counterClockSelect(ccSel), .syncTrigger(syncTrigger),
    .extLine(extLine), .extClockPick(extClockPick), .chanIrq(chanIrq)
  );

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts cycles with the trigger pulse high
  always @(negedge clk) begin
    if (syncTrigger === 1'b1) pulses <= pulses + 1;
  end

  // Verdict and end of run
  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Comparisons
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_word({30'h0, got}, {30'h0, exp});
  endtask : chk_resp

  // Bounded wait step
  task automatic tick(ref int n);
    n++;
    if (n > 100) begin
      n_mismatch++;
      end_sim();
    end
  endtask : tick

  // AXI4-Lite write; address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    logic pa;
    logic pw;
    logic ta;
    logic tw;
    logic gb;
    n = 0;
    pa = 1'b1;
    pw = 1'b1;
    gb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa && (awready === 1'b1);
      tw = pw && (wready === 1'b1);
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (ta) pa = 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tw) pw = 1'b0;
      tick(n);
    end
    while (!gb) begin
      @(negedge clk);
      gb = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      tick(n);
    end
    bready <= 1'b0;
  endtask : axi_write

  // AXI4-Lite read
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    logic t;
    n = 0;
    t = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(negedge clk);
      t = (arready === 1'b1);
      @(posedge clk);
      tick(n);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      tick(n);
    end
    rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rsp);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    axi_read(a, rd, rsp);
    chk_word(rd, e);
  endtask : rc

  // Reset values and read-only identity registers
  task automatic t_reset;
    rc(8'h2c, 32'h0);
    rc(8'h6c, 32'h0);
    rc(8'hac, 32'h0);
    rc(8'hc4, 32'h0);
    rc(8'hf8, 32'h210);
    rc(8'hfc, {12'h0, timer_block_pkg::VARIANT_NUMBER, 4'h0,
               timer_block_pkg::REVISION_NUMBER});
  endtask : t_reset

  // Mask set, clear, zero writes and read-only mask on channel 1
  task automatic t_mask;
    axi_write(8'h64, 32'ha5, rsp);
    chk_resp(rsp, timer_block_pkg::RESP_OKAY);
    rc(8'h6c, 32'ha5);
    wr(8'h64, 32'h0);
    rc(8'h6c, 32'ha5);
    wr(8'h68, 32'h21);
    rc(8'h6c, 32'h84);
    wr(8'h68, 32'h0);
    wr(8'h6c, 32'hff);
    rc(8'h6c, 32'h84);
    rc(8'h2c, 32'h0);
    rc(8'hac, 32'h0);
    wr(8'h64, 32'h5a);
    rc(8'h6c, 32'hde);
    wr(8'h68, 32'hff);
    rc(8'h6c, 32'h0);
    // Low byte lane off: write answered but mask untouched
    @(posedge clk);
    wstrb <= 4'he;
    axi_write(8'h64, 32'hff, rsp);
    chk_resp(rsp, timer_block_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rc(8'h6c, 32'h0);
  endtask : t_mask

  // Unmapped addresses are refused with no effect
  task automatic t_unmapped;
    axi_write(8'h30, 32'hff, rsp);
    chk_resp(rsp, timer_block_pkg::RESP_SLVERR);
    axi_read(8'h34, rd, rsp);
    chk_resp(rsp, timer_block_pkg::RESP_SLVERR);
    rc(8'h2c, 32'h0);
  endtask : t_unmapped

  // Software trigger only for a one in bit 0
  task automatic t_sync;
    int p0;
    p0 = pulses;
    wr(8'hc0, 32'h1);
    repeat (2) @(posedge clk);
    chk_word(pulses - p0, 32'h1);
    wr(8'hc0, 32'h0);
    wr(8'hc0, 32'hfffffffe);
    repeat (2) @(posedge clk);
    chk_word(pulses - p0, 32'h1);
  endtask : t_sync

  // Expected lines {2, 1, 0} for one selector code on all three lines
  function automatic logic [2:0] exp_line(input logic [1:0] c,
                                          input logic [2:0] p,
                                          input logic [2:0] w);
    if (c == 2'h0) return p;
    if (c == 2'h1) return 3'h0;
    if (c == 2'h2) return {w[0], w[0], w[1]};
    return {w[1], w[2], w[2]};
  endfunction : exp_line

  // External line routing and counter clock pick for each code
  task automatic t_route;
    logic [2:0] p;
    logic [2:0] w;
    logic [2:0] e;
    logic [1:0] c;
    for (int k = 0; k < 8; k++) begin
      c = k[1:0];
      p = k[2] ? 3'b010 : 3'b101;
      w = k[2] ? 3'b100 : 3'b011;
      @(posedge clk);
      clockPin <= p;
      waveA <= w;
      ccSel <= {3'd7, 3'd6, 3'd5};
      wr(8'hc4, {26'h0, c, c, c});
      rc(8'hc4, {26'h0, c, c, c});
      repeat (4) @(posedge clk);
      @(negedge clk);
      e = exp_line(c, p, w);
      chk_word({29'h0, extLine}, {29'h0, e});
      chk_word({29'h0, extClockPick}, {29'h0, e});
      @(posedge clk);
      ccSel <= {3'd6, 3'd7, 3'd5};
      @(negedge clk);
      chk_word({29'h0, extClockPick}, {29'h0, e[1], e[2], e[0]});
      // Internal clock codes never pick an external line
      @(posedge clk);
      ccSel <= {3'd4, 3'd1, 3'd0};
      @(negedge clk);
      chk_word({29'h0, extClockPick}, 32'h0);
    end
  endtask : t_route

  task automatic pulse(input int ch, input logic [7:0] v);
    @(posedge clk);
    eventPulse[ch] <= v;
    @(posedge clk);
    eventPulse[ch] <= 8'h0;
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic irq(input logic [2:0] e);
    @(negedge clk);
    chk_word({29'h0, chanIrq}, {29'h0, e});
  endtask : irq

  // Interrupt follows flags and mask; status read clears flags
  task automatic t_irq;
    pulse(2, 8'h08);
    irq(3'b000);
    wr(8'ha4, 32'h10);
    irq(3'b000);
    wr(8'ha4, 32'h08);
    irq(3'b100);
    wr(8'ha8, 32'h08);
    irq(3'b000);
    wr(8'ha4, 32'h08);
    irq(3'b100);
    rc(8'ha0, 32'h08);
    irq(3'b000);
    rc(8'ha0, 32'h0);
    pulse(0, 8'h01);
    wr(8'h24, 32'h01);
    irq(3'b001);
    rc(8'h20, 32'h01);
    irq(3'b000);
    // Event arriving while already unmasked
    pulse(2, 8'h10);
    irq(3'b100);
    rc(8'ha0, 32'h10);
    irq(3'b000);
  endtask : t_irq

  // Main sequence
  initial begin
    rstn = 1'b0;
    awaddr = 8'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    eventPulse = '0;
    waveA = 3'h0;
    clockPin = 3'h0;
    ccSel = 9'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_mask();
    t_unmapped();
    t_sync();
    t_route();
    t_irq();
    end_sim();
  end
endmodule : testbench
